// *** tmp_pkg.sv ***
// constants shared by the transmit multifunction pin mux
package tmp_pkg;
   // ==========================================================
   // pin function selector codes
   localparam int SEL_W = 4;
   localparam logic [3:0] FN_TX_CLK_IN = 4'h3;
   localparam logic [3:0] FN_LINE_CLK_OUT = 4'h7;
   localparam logic [3:0] FN_TRI_HIGH = 4'h8;
   localparam logic [3:0] FN_GPI = 4'h9;
   localparam logic [3:0] FN_OUT_HIGH = 4'ha;
   localparam logic [3:0] FN_OUT_LOW = 4'hb;
   localparam logic [3:0] FN_NEG_RAIL = 4'hd;
   localparam logic [3:0] FN_TRI_LOW = 4'he;
   // every pin leaves reset as a general input
   localparam logic [3:0] SEL_RESET = FN_GPI;
   localparam int PINS_PER_PORT = 3;
   // ==========================================================
   // register map: one 16-byte block per line port
   localparam int PORT_SH = 4;
   localparam logic [3:0] OFF_PC1 = 4'h0;
   localparam logic [3:0] OFF_PC2 = 4'h4;
   localparam logic [3:0] OFF_CTRL = 4'h8;
   localparam logic [3:0] OFF_STAT = 4'hc;
   // ==========================================================
   // field positions
   localparam int PC1_A_LSB = 0;
   localparam int PC1_B_LSB = 4;
   localparam int PC1_W = 8;
   localparam int CTRL_TRI_BIT = 0;
   localparam int CTRL_DUAL_BIT = 1;
   localparam int CTRL_EDGE_BIT = 2;
   localparam int CTRL_W = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int STAT_TRI_BIT = 3;
   localparam int STAT_CLK_BIT = 4;
   localparam int STAT_NEG_BIT = 5;
   localparam int STAT_W = 6;
endpackage

// *** tmp_pin_if.sv ***
// signals between the mux core and one pin slice
`timescale 1ns/1ps
interface tmp_pin_if;
   logic [3:0] sel;      // function selector of this pin
   logic lvl;            // synchronised pin level
   logic line_clk;       // internal line clock level
   logic launch;         // selected framer clock edge
   logic gpi_lvl;        // level seen as general input
   logic tri_req;        // tristate request from this pin
   logic neg_lvl;        // negative rail level
   logic clk_sel;        // pin carries the transmit clock
   logic clk_lvl;        // transmit clock level
   logic pin_out;        // registered pin drive value
   logic pin_oe_n;       // registered enable, low drives
   modport core (output sel, output lvl, output line_clk,
      output launch, input gpi_lvl, input tri_req,
      input neg_lvl, input clk_sel, input clk_lvl,
      input pin_out, input pin_oe_n);
   modport slice (input sel, input lvl, input line_clk,
      input launch, output gpi_lvl, output tri_req,
      output neg_lvl, output clk_sel, output clk_lvl,
      output pin_out, output pin_oe_n);
endinterface

// *** tmp_sync.sv ***
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module tmp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q; // first stage, read only by q
   // ==========================================================
   // two stages; the second alone feeds logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** tmp_pin_slice.sv ***
// one transmit multifunction pin: decode and drive
`timescale 1ns/1ps
module tmp_pin_slice (
   input wire logic clk,
   input wire logic rst_n,
   tmp_pin_if.slice pif
);
   // ==========================================================
   // input-side decode, from the selector and the pin level
   always_comb begin
      // the selected function alone gives meaning
      pif.gpi_lvl = (pif.sel == tmp_pkg::FN_GPI) & pif.lvl;
      // active high or active low tristate request
      pif.tri_req =
         ((pif.sel == tmp_pkg::FN_TRI_HIGH) & pif.lvl) |
         ((pif.sel == tmp_pkg::FN_TRI_LOW) & ~pif.lvl);
      pif.neg_lvl = (pif.sel == tmp_pkg::FN_NEG_RAIL) &
         pif.lvl;
      pif.clk_sel = (pif.sel == tmp_pkg::FN_TX_CLK_IN);
      pif.clk_lvl = pif.clk_sel & pif.lvl;
   end
   // ==========================================================
   // output drive; direction follows the function
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pif.pin_out <= 1'b0;
         pif.pin_oe_n <= 1'b1; // input after reset
      end else begin
         unique case (pif.sel)
            tmp_pkg::FN_OUT_HIGH: begin
               pif.pin_out <= 1'b1;
               pif.pin_oe_n <= 1'b0;
            end
            tmp_pkg::FN_OUT_LOW: begin
               pif.pin_out <= 1'b0; // low, as named
               pif.pin_oe_n <= 1'b0;
            end
            tmp_pkg::FN_LINE_CLK_OUT: begin
               pif.pin_oe_n <= 1'b0;
               // launched only on the chosen framer edge
               if (pif.launch) begin
                  pif.pin_out <= pif.line_clk;
               end
            end
            default: begin
               // inputs and unassigned codes float
               pif.pin_out <= 1'b0;
               pif.pin_oe_n <= 1'b1;
            end
         endcase
      end
   end
endmodule

// *** tmp_tx_pin_mux.sv ***
// transmit multifunction pin mux with apb register access
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module tmp_tx_pin_mux #(
   parameter int NUM_PORTS = 8,
   parameter int ADDR_W = 8
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3*NUM_PORTS-1:0] TX_PIN_IN,
   output logic [3*NUM_PORTS-1:0] TX_PIN_OUT,
   output logic [3*NUM_PORTS-1:0] TX_PIN_OE_N,
   input wire logic FRAMER_TX_CLK,
   input wire logic [NUM_PORTS-1:0] TX_LINE_CLK,
   output logic [NUM_PORTS-1:0] TX_LINE_TRISTATE,
   output logic [NUM_PORTS-1:0] TX_NEG_DATA,
   output logic [NUM_PORTS-1:0] TX_EXT_CLK,
   output logic [NUM_PORTS-1:0] TX_EXT_CLK_SEL
);
   // ==========================================================
   // sizes
   localparam int NP = tmp_pkg::PINS_PER_PORT * NUM_PORTS;
   localparam int PORT_W = (NUM_PORTS > 1) ?
      $clog2(NUM_PORTS) : 1;
   localparam int SH = tmp_pkg::PORT_SH;

   // refuse sizes the decoder cannot serve
   if (NUM_PORTS < 1 || ADDR_W < SH + PORT_W ||
      ADDR_W > 16) begin : g_bad_size
      $error("tmp_tx_pin_mux: unsupported size");
   end

   // ==========================================================
   // configuration registers, one set per port
   logic [tmp_pkg::PC1_W-1:0] pc1_q [NUM_PORTS]; // pins a, b
   logic [tmp_pkg::SEL_W-1:0] pc2_q [NUM_PORTS]; // pin c
   logic [tmp_pkg::CTRL_W-1:0] ctrl_q [NUM_PORTS];

   // bus answer registers
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata_d;

   // decode of the held address
   logic [PORT_W-1:0] port_idx;
   logic [3:0] reg_off;
   logic addr_ok;
   logic setup;
   logic wr_en;

   // synchronised framer clock and pins
   logic [NP:0] sync_q;
   logic fclk_s;
   logic fclk_prev_q;
   logic fclk_rise;
   logic fclk_fall;
   logic [NUM_PORTS-1:0] launch;

   // per-pin selectors and decoded flags
   logic [3:0] pin_sel [NP];
   logic [NP-1:0] gpi_v;
   logic [NP-1:0] tri_v;
   logic [NP-1:0] neg_v;
   logic [NP-1:0] csel_v;
   logic [NP-1:0] clk_v;

   // per-port output registers
   logic [NUM_PORTS-1:0] tristate_q;
   logic [NUM_PORTS-1:0] neg_q;
   logic [NUM_PORTS-1:0] extclk_q;
   logic [NUM_PORTS-1:0] extsel_q;

   // ==========================================================
   // input synchronisation
   // pins and framer clock come from outside this clock domain;
   // the framer clock is only sampled, so it must stay well
   // below half of the reference rate
   tmp_sync #(
      .WIDTH(NP + 1)
   ) u_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .d({FRAMER_TX_CLK, TX_PIN_IN}),
      .q(sync_q)
   );

   assign fclk_s = sync_q[NP];

   // ==========================================================
   // framer clock edge detection
   // delay of the synchronised clock for edge finding
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fclk_prev_q <= 1'b0;
      end else begin
         fclk_prev_q <= fclk_s;
      end
   end

   assign fclk_rise = fclk_s & ~fclk_prev_q;
   assign fclk_fall = ~fclk_s & fclk_prev_q;

   // per-port edge choice: bit set picks falling
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         launch[p] = ctrl_q[p][tmp_pkg::CTRL_EDGE_BIT] ?
            fclk_fall : fclk_rise;
      end
   end

   // ==========================================================
   // selector fan-out to the pins
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         pin_sel[3*p] = pc1_q[p][tmp_pkg::PC1_A_LSB +: 4];
         pin_sel[3*p+1] = pc1_q[p][tmp_pkg::PC1_B_LSB +: 4];
         pin_sel[3*p+2] = pc2_q[p];
      end
   end

   // ==========================================================
   // pin slices, one per multifunction pin
   for (genvar i = 0; i < NP; i++) begin : g_pin
      tmp_pin_if pif();

      assign pif.sel = pin_sel[i];
      assign pif.lvl = sync_q[i];
      assign pif.line_clk = TX_LINE_CLK[i/3];
      assign pif.launch = launch[i/3];
      assign gpi_v[i] = pif.gpi_lvl;
      assign tri_v[i] = pif.tri_req;
      assign neg_v[i] = pif.neg_lvl;
      assign csel_v[i] = pif.clk_sel;
      assign clk_v[i] = pif.clk_lvl;
      // both come straight from the slice flops
      assign TX_PIN_OUT[i] = pif.pin_out;
      assign TX_PIN_OE_N[i] = pif.pin_oe_n;

      tmp_pin_slice u_slice (
         .clk(REF_CLK),
         .rst_n(RST_N),
         .pif(pif)
      );
   end

   // ==========================================================
   // line tristate per port
   // the three pins are simply ored; the host may set one active high
   // and one active low tristate input per port, so no arbitration is needed
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tristate_q <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            tristate_q[p] <= ctrl_q[p][tmp_pkg::CTRL_TRI_BIT] |
               (|tri_v[3*p +: 3]);
         end
      end
   end

   // ==========================================================
   // negative rail data latch
   // only meaningful in dual rail mode; otherwise held low
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         neg_q <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (!ctrl_q[p][tmp_pkg::CTRL_DUAL_BIT]) begin
               neg_q[p] <= 1'b0;
            end else if (launch[p]) begin
               neg_q[p] <= |neg_v[3*p +: 3];
            end
         end
      end
   end

   // ==========================================================
   // transmit clock from the framer
   // the level is forwarded, not used as a clock here
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         extclk_q <= '0;
         extsel_q <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            extsel_q[p] <= |csel_v[3*p +: 3];
            extclk_q[p] <= |clk_v[3*p +: 3];
         end
      end
   end

   assign TX_LINE_TRISTATE = tristate_q;
   assign TX_NEG_DATA = neg_q;
   assign TX_EXT_CLK = extclk_q;
   assign TX_EXT_CLK_SEL = extsel_q;

   // ==========================================================
   // apb address decode
   assign port_idx = PADDR[SH +: PORT_W];
   assign reg_off = PADDR[3:0];
   // word aligned and inside the populated port blocks
   assign addr_ok = (PADDR[1:0] == 2'h0) &&
      ((PADDR >> SH) < ADDR_W'(NUM_PORTS));
   assign setup = PSEL & ~PENABLE;
   // a write lands only at the completing edge
   assign wr_en = PSEL & PENABLE & pready_q & PWRITE &
      addr_ok;

   // read data, chosen during setup
   always_comb begin
      rdata_d = 32'h0;
      if (addr_ok) begin
         unique case (reg_off)
            tmp_pkg::OFF_PC1: rdata_d = 32'(pc1_q[port_idx]);
            tmp_pkg::OFF_PC2: rdata_d = 32'(pc2_q[port_idx]);
            tmp_pkg::OFF_CTRL: rdata_d = 32'(ctrl_q[port_idx]);
            tmp_pkg::OFF_STAT: begin
               // pin levels of general inputs
               rdata_d[2:0] = gpi_v[3*port_idx +: 3];
               rdata_d[tmp_pkg::STAT_TRI_BIT] =
                  tristate_q[port_idx];
               rdata_d[tmp_pkg::STAT_CLK_BIT] =
                  extclk_q[port_idx];
               rdata_d[tmp_pkg::STAT_NEG_BIT] = neg_q[port_idx];
            end
            default: rdata_d = 32'h0; // unaligned, not reached
         endcase
      end
   end

   // ==========================================================
   // apb answer: ready in the first access cycle
   // one fixed wait-free access keeps the read data registered
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~addr_ok;
         if (setup) begin
            prdata_q <= PWRITE ? 32'h0 : rdata_d;
         end
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PRDATA = prdata_q;

   // ==========================================================
   // register writes; status ignores writes
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            // every pin starts as an input
            pc1_q[p] <= {tmp_pkg::SEL_RESET, tmp_pkg::SEL_RESET};
            pc2_q[p] <= tmp_pkg::SEL_RESET;
            ctrl_q[p] <= tmp_pkg::CTRL_RESET;
         end
      end else if (wr_en) begin
         unique case (reg_off)
            tmp_pkg::OFF_PC1: begin
               pc1_q[port_idx] <= PWDATA[tmp_pkg::PC1_W-1:0];
            end
            tmp_pkg::OFF_PC2: begin
               pc2_q[port_idx] <= PWDATA[tmp_pkg::SEL_W-1:0];
            end
            tmp_pkg::OFF_CTRL: begin
               ctrl_q[port_idx] <= PWDATA[tmp_pkg::CTRL_W-1:0];
            end
            default: begin
               // status is read only
            end
         endcase
      end
   end
endmodule

// *** tmp_monitor.sv ***
// assertion checker watching the transmit pin mux ports
`timescale 1ns/1ps
module tmp_monitor #(
   parameter int NUM_PORTS = 8,
   parameter int ADDR_W = 8
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [3*NUM_PORTS-1:0] TX_PIN_OUT,
   input wire logic [3*NUM_PORTS-1:0] TX_PIN_OE_N
);
   // ==========================================================
   // helpers
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic apb_wr; // completed write of any kind
   logic pa_wr; // completed write to a pin a selector field
   logic [4:0] pa_ix; // pin a index of the addressed port
   assign apb_wr = PSEL && PENABLE && PWRITE && PREADY;
   assign pa_wr = apb_wr && PADDR[3:0] == 4'h0 && !PADDR[7];
   assign pa_ix = 5'(3 * PADDR[6:4]);
   // ==========================================================
   // assertions
   property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
   a_rdy: assert property (p_rdy)
      else $error("no ready after setup");
   property p_pulse; PREADY |=> !PREADY; endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   property p_err;
      PREADY && !PWRITE && PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == '0;
   endproperty
   a_err: assert property (p_err)
      else $error("misaligned read not refused");
   // pins take the new selector one edge after the write edge
   property p_hi;
      pa_wr && PWDATA[3:0] == 4'ha |=> ##1
         !TX_PIN_OE_N[$past(pa_ix, 2)] && TX_PIN_OUT[$past(pa_ix, 2)];
   endproperty
   a_hi: assert property (p_hi)
      else $error("fixed high output missing");
   property p_lo;
      pa_wr && PWDATA[3:0] == 4'hb |-> ##2
         !TX_PIN_OE_N[$past(pa_ix, 2)] && !TX_PIN_OUT[$past(pa_ix, 2)];
   endproperty
   a_lo: assert property (p_lo)
      else $error("fixed low output missing");
   property p_in;
      pa_wr && PWDATA[3:0] == 4'h9 |=> ##1 TX_PIN_OE_N[$past(pa_ix, 2)];
   endproperty
   a_in: assert property (p_in)
      else $error("general input drives pin");
   property p_unk;
      pa_wr && PWDATA[3:0] == 4'hf |=> ##1 TX_PIN_OE_N[$past(pa_ix, 2)];
   endproperty
   a_unk: assert property (p_unk)
      else $error("unassigned code drives pin");
   property p_dir; !$stable(TX_PIN_OE_N) |-> $past(apb_wr, 2); endproperty
   a_dir: assert property (p_dir)
      else $error("direction changed without selector write");
   property p_rst; !$past(RST_N) |-> &TX_PIN_OE_N; endproperty
   a_rst: assert property (p_rst)
      else $error("pin driven after reset");
endmodule

// *** tmp_framer.sv ***
// framer model: free running transmit clock and pin drivers
`timescale 1ns/1ps
module tmp_framer (
   input wire logic [23:0] drv,
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe_n,
   output logic fclk,
   output logic [23:0] pin_lvl
);
   // toggles on reference falling edges, away from the sampling edge
   initial fclk = 1'b0;
   always #300 fclk = ~fclk;
   // framer drives pins the device leaves as inputs
   assign pin_lvl = (pin_oe_n & drv) | (~pin_oe_n & pin_out);
endmodule

// *** tb_top.sv ***
// self-checking bench for the transmit pin mux
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // signals and model state
   logic REF_CLK = 1'b0;
   logic RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FRAMER_TX_CLK;
   logic [7:0] PADDR, TX_LINE_CLK, TX_LINE_TRISTATE, TX_NEG_DATA;
   logic [7:0] TX_EXT_CLK, TX_EXT_CLK_SEL;
   logic [31:0] PWDATA, PRDATA;
   logic [23:0] TX_PIN_IN, TX_PIN_OUT, TX_PIN_OE_N, drv;
   logic [3:0] sel [24]; // selector model
   logic [2:0] ctrl [8]; // control model
   logic [3:0] codes [$] = '{4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd,
      4'he, 4'h0, 4'hf};
   int n_mismatch, n_checks, seed;
   always #50 REF_CLK = ~REF_CLK;
   tmp_tx_pin_mux i_tmp_tx_pin_mux (.REF_CLK(REF_CLK), .RST_N(RST_N),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .TX_PIN_IN(TX_PIN_IN), .TX_PIN_OUT(TX_PIN_OUT),
      .TX_PIN_OE_N(TX_PIN_OE_N), .FRAMER_TX_CLK(FRAMER_TX_CLK),
      .TX_LINE_CLK(TX_LINE_CLK), .TX_LINE_TRISTATE(TX_LINE_TRISTATE),
      .TX_NEG_DATA(TX_NEG_DATA), .TX_EXT_CLK(TX_EXT_CLK),
      .TX_EXT_CLK_SEL(TX_EXT_CLK_SEL));
   tmp_framer i_tmp_framer (.drv(drv), .pin_out(TX_PIN_OUT),
      .pin_oe_n(TX_PIN_OE_N), .fclk(FRAMER_TX_CLK), .pin_lvl(TX_PIN_IN));
   // ==========================================================
   // tasks
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] pa(input int p, input int o);
      return 8'(p * 16 + o);
   endfunction
   // one apb transfer; the request is held until ready is sampled
   task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic ee);
      int n;
      n = 0;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'b1);
      chk(32'(n), 32'h1);
      if (!w)
         chk(PRDATA, e);
      chk(PSLVERR, ee);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge REF_CLK);
   endtask
   // model all outputs and status, then compare
   task automatic check_all;
      logic [23:0] eoe, eout;
      logic [7:0] etri, eneg, esel, eclk;
      logic [5:0] est [8];
      int p;
      eoe = '1;
      eout = '0;
      {etri, eneg, esel, eclk} = '0;
      for (int i = 0; i < 8; i++) est[i] = '0;
      for (int i = 0; i < 24; i++) begin
         p = i / 3;
         case (sel[i])
            4'h3: begin esel[p] = 1'b1; eclk[p] |= drv[i]; end
            4'h7: begin eoe[i] = 1'b0; eout[i] = TX_LINE_CLK[p]; end
            4'h8: etri[p] |= drv[i];
            4'h9: est[p][i%3] = drv[i];
            4'ha: begin eoe[i] = 1'b0; eout[i] = 1'b1; end
            4'hb: eoe[i] = 1'b0;
            4'hd: eneg[p] |= drv[i] & ctrl[p][1];
            4'he: etri[p] |= ~drv[i];
            default: ;
         endcase
      end
      for (int q = 0; q < 8; q++) begin
         etri[q] |= ctrl[q][0];
         est[q][5:3] = {eneg[q], eclk[q], etri[q]};
      end
      chk(TX_PIN_OE_N, eoe);
      chk(TX_PIN_OUT & ~eoe, eout);
      chk(TX_LINE_TRISTATE, etri);
      chk(TX_NEG_DATA, eneg);
      chk({TX_EXT_CLK, TX_EXT_CLK_SEL}, {eclk, esel});
      for (int q = 0; q < 8; q++) begin
         acc(0, pa(q, 0), 0, {sel[3*q+1], sel[3*q]}, 0);
         acc(0, pa(q, 4), 0, sel[3*q+2], 0);
         acc(0, pa(q, 8), 0, ctrl[q], 0);
         acc(0, pa(q, 12), 0, est[q], 0);
      end
   endtask
   task automatic do_reset;
      RST_N <= 1'b0;
      repeat (16) @(posedge REF_CLK);
      RST_N <= 1'b1;
      foreach (sel[i]) sel[i] = 4'h9;
      foreach (ctrl[i]) ctrl[i] = 3'h0;
      @(posedge REF_CLK);
      chk(TX_PIN_OE_N, 32'hffffff);
      chk(TX_PIN_OUT, 32'h0);
      repeat (20) @(posedge REF_CLK);
      check_all;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [3:0] c;
      logic [15:0] used;
      logic [31:0] r;
      logic lc;
      seed = 32'h8f0e;
      {n_mismatch, n_checks} = '0;
      {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      TX_LINE_CLK = 8'h0;
      drv = '1;
      @(posedge REF_CLK);
      do_reset;
      // refused and ignored accesses; their error flags and the refused read's zero data are checked
      acc(1, 8'h02, 32'ha, 0, 1);
      acc(0, 8'h81, 0, 0, 1);
      acc(1, 8'h90, 32'ha, 0, 1);
      acc(1, 8'h0c, '1, 0, 0);
      for (int it = 0; it < 12; it++) begin
         drv <= 24'($random(seed));
         TX_LINE_CLK <= 8'($random(seed));
         for (int p = 0; p < 8; p++) begin
            used = '0;
            for (int k = 0; k < 3; k++) begin
               c = codes[$unsigned($random(seed)) % 10];
               // each input function except general input may sit on one pin of a port
               if (c inside {4'h3, 4'h8, 4'hd, 4'he} && used[c])
                  c = 4'h9;
               used[c] = 1'b1;
               sel[3*p+k] = c;
            end
            ctrl[p] = 3'($random(seed));
            r = $random(seed);
            acc(1, pa(p, 0), {r[31:8], sel[3*p+1], sel[3*p]}, 0, 0);
            acc(1, pa(p, 4), {r[31:4], sel[3*p+2]}, 0, 0);
            acc(1, pa(p, 8), {r[31:3], ctrl[p]}, 0, 0);
         end
         repeat (20) @(posedge REF_CLK);
         check_all;
      end
      // line clock out changes only on the chosen framer edge
      for (int e = 0; e < 2; e++) begin
         acc(1, pa(0, 0), 32'h97, 0, 0);
         acc(1, pa(0, 8), e ? 32'h4 : 32'h0, 0, 0);
         @(negedge FRAMER_TX_CLK);
         @(posedge REF_CLK);
         lc = TX_LINE_CLK[0];
         TX_LINE_CLK[0] <= !lc;
         repeat (4) @(posedge REF_CLK);
         chk(TX_PIN_OUT[0], lc ^ 1'(e));
         repeat (6) @(posedge REF_CLK);
         chk(TX_PIN_OUT[0], !lc);
      end
      do_reset;
      complete_run;
   end
   // watchdog well beyond the expected run length
   initial begin
      #2000000;
      n_mismatch++;
      complete_run;
   end
endmodule
bind tmp_tx_pin_mux tmp_monitor #(.NUM_PORTS(NUM_PORTS), .ADDR_W(ADDR_W))
   i_tmp_monitor (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_OE_N(TX_PIN_OE_N));
